// file: include/sshe_defines.vh
// Purpose: constants for the store/subtract/standby execution unit
// Assumes: included by bare name, definitions only
// Notes: opcodes are first bytes; standby is a two-byte prefixed opcode
`ifndef SSHE_DEFINES_VH
`define SSHE_DEFINES_VH
`define SSHE_OP_SEXT 8'hb7
`define SSHE_OP_PREFIX 8'h18
`define SSHE_OP_STANDBY 8'h3e
`define SSHE_OP_ST_A_DIR 8'h5a
`define SSHE_OP_ST_A_EXT 8'h7a
`define SSHE_OP_ST_A_IDX 8'h6a
`define SSHE_OP_ST_B_DIR 8'h5b
`define SSHE_OP_ST_B_EXT 8'h7b
`define SSHE_OP_ST_B_IDX 8'h6b
`define SSHE_OP_ST_D_DIR 8'h5c
`define SSHE_OP_ST_D_EXT 8'h7c
`define SSHE_OP_ST_D_IDX 8'h6c
`define SSHE_OP_ST_Y_DIR 8'h5d
`define SSHE_OP_ST_Y_EXT 8'h7d
`define SSHE_OP_ST_Y_IDX 8'h6d
`define SSHE_OP_ST_X_DIR 8'h5e
`define SSHE_OP_ST_X_EXT 8'h7e
`define SSHE_OP_ST_X_IDX 8'h6e
`define SSHE_OP_ST_SP_DIR 8'h5f
`define SSHE_OP_ST_SP_EXT 8'h7f
`define SSHE_OP_ST_SP_IDX 8'h6f
`define SSHE_OP_SUB_A_IMM 8'h80
`define SSHE_OP_SUB_A_DIR 8'h90
`define SSHE_OP_SUB_A_EXT 8'hb0
`define SSHE_OP_SUB_A_IDX 8'ha0
`define SSHE_OP_SUB_B_IMM 8'hc0
`define SSHE_OP_SUB_B_DIR 8'hd0
`define SSHE_OP_SUB_B_EXT 8'hf0
`define SSHE_OP_SUB_B_IDX 8'he0
`define SSHE_OP_SUB_D_IMM 8'h83
`define SSHE_OP_SUB_D_DIR 8'h93
`define SSHE_OP_SUB_D_EXT 8'hb3
`define SSHE_OP_SUB_D_IDX 8'ha3
// flag bit positions in the condition flags register
`define SSHE_CC_STOPDIS 7
`define SSHE_CC_XMASK 6
`define SSHE_CC_NEG 3
`define SSHE_CC_ZERO 2
`define SSHE_CC_OVF 1
`define SSHE_CC_CARRY 0
// sign-extend postbyte codes
`define SSHE_SRC_A 3'h0
`define SSHE_SRC_B 3'h1
`define SSHE_SRC_CC 3'h2
`define SSHE_DST_TMP 4'h3
`define SSHE_DST_D 4'h4
`define SSHE_DST_X 4'h5
`define SSHE_DST_Y 4'h6
`define SSHE_DST_SP 4'h7
// reset values and standby timing
`define SSHE_CC_RESET 8'hd0
`define SSHE_NOP_CYCLES 2'h2
`define SSHE_RECOVER_CYCLES 2'h2
`endif

// file: verif/sshe_exec_monitor.sv
// Purpose: port-level checks on the store/subtract/standby unit
// Assumes: one clock, synchronous active-low reset
// Notes: standby entry needs stop-disable clear, unreachable from reset
`timescale 1ns/100ps
module sshe_exec_monitor
(
  input wire ref_clk,
  input wire reset_n,
  input wire instr_valid,
  input wire instr_ready,
  input wire [7:0] instr_opcode,
  input wire instr_page2,
  input wire [7:0] instr_postbyte,
  input wire [15:0] instr_addr,
  input wire [15:0] instr_operand,
  input wire instr_done,
  input wire mem_wr_en,
  input wire [15:0] mem_wr_addr,
  input wire [7:0] mem_wr_data,
  input wire stack_req,
  input wire clocks_stop,
  input wire [7:0] accum_a,
  input wire [7:0] accum_b,
  input wire [15:0] index_x,
  input wire [7:0] condition_flags_register
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  // request qualifiers, page-two kept apart from plain opcodes
  wire take = instr_valid && instr_ready && !instr_page2;
  wire take2 = instr_valid && instr_ready && instr_page2 && instr_opcode == 8'h3e;
  wire [7:0] op = instr_opcode;
  wire [7:0] cc = condition_flags_register;
  wire st = (op[7:4] == 4'h5 || op[7:4] == 4'h6 || op[7:4] == 4'h7) && op[3:0] >= 4'ha;
  // high byte first, low byte one address up
  sequence s_hi;
    mem_wr_en && mem_wr_addr == $past(instr_addr) && mem_wr_data == $past(accum_a);
  endsequence
  sequence s_lo;
    mem_wr_en && instr_done && mem_wr_addr == $past(instr_addr, 2) + 16'h0001
      && mem_wr_data == $past(accum_b, 2);
  endsequence
  a_dbl_store_pair: assert property (take && op == 8'h5c |=> s_hi ##1 s_lo)
    else $error("double store bytes wrong");
  a_store_a_byte: assert property (take && (op == 8'h5a || op == 8'h7a) |=>
    mem_wr_en && mem_wr_data == $past(accum_a) && accum_a == $past(accum_a))
    else $error("store a wrong");
  a_store_b_byte: assert property (take && op == 8'h6b |=>
    mem_wr_en && mem_wr_data == $past(accum_b) && accum_b == $past(accum_b))
    else $error("store b wrong");
  a_store_flags: assert property (take && st |=> !cc[1] && cc[0] == $past(cc[0]))
    else $error("store flags wrong");
  a_sub_a_result: assert property (take && op == 8'h80 |=>
    instr_done && accum_a == $past(accum_a) - $past(instr_operand[7:0]))
    else $error("subtract result wrong");
  a_sub_borrow: assert property (take && op == 8'h80 |=>
    cc[0] == ($past(instr_operand[7:0]) > $past(accum_a)))
    else $error("borrow wrong");
  a_sub_ovf: assert property (take && op == 8'h80 |=> cc[1] ==
    ($past(accum_a[7]) != $past(instr_operand[7]) && accum_a[7] != $past(accum_a[7])))
    else $error("overflow wrong");
  a_sext_x: assert property (take && op == 8'hb7 && instr_postbyte[6:0] == 7'h05 |=>
    index_x == {{8{$past(accum_a[7])}}, $past(accum_a)})
    else $error("sign extend wrong");
  a_stop_nop: assert property (take2 && cc[7] |=>
    !instr_done && !stack_req ##1 instr_done && !clocks_stop)
    else $error("disabled standby wrong");
  a_stop_entry: assert property (take2 && !cc[7] |=> stack_req ##1 clocks_stop)
    else $error("standby entry wrong");
endmodule
bind sshe_exec sshe_exec_monitor sshe_exec_monitor_i (.ref_clk(ref_clk), .reset_n(reset_n),
  .instr_valid(instr_valid), .instr_ready(instr_ready), .instr_opcode(instr_opcode),
  .instr_page2(instr_page2), .instr_postbyte(instr_postbyte), .instr_addr(instr_addr),
  .instr_operand(instr_operand), .instr_done(instr_done), .mem_wr_en(mem_wr_en),
  .mem_wr_addr(mem_wr_addr), .mem_wr_data(mem_wr_data), .stack_req(stack_req),
  .clocks_stop(clocks_stop), .accum_a(accum_a), .accum_b(accum_b), .index_x(index_x),
  .condition_flags_register(condition_flags_register));

// file: verif/sshe_mem_model.sv
// Purpose: byte memory on the core write port
// Assumes: a byte lands on the rising edge while mem_wr_en is high
// Notes: 256 bytes, address wraps; the bench reads the array directly
`timescale 1ns/100ps
module sshe_mem_model
(
  input wire ref_clk,
  input wire mem_wr_en,
  input wire [15:0] mem_wr_addr,
  input wire [7:0] mem_wr_data
);
  reg [7:0] mem [0:255];
  // capture writes; byte order is judged by the bench
  always @(posedge ref_clk)
    if (mem_wr_en === 1'b1)
      mem[mem_wr_addr[7:0]] <= mem_wr_data;
endmodule

// file: verif/testbench.sv
// Purpose: self-checking bench for the execution unit
// Assumes: flags leave reset with stop-disable set
// Notes: standby is reached by clearing stop-disable in the flags in place
`timescale 1ns/100ps
module testbench;
  reg ref_clk = 1'b0;
  reg reset_n = 1'b0;
  reg instr_valid = 1'b0;
  reg [7:0] instr_opcode = 8'h00;
  reg instr_page2 = 1'b0;
  reg [7:0] instr_postbyte = 8'h00;
  reg [15:0] instr_addr = 16'h0000;
  reg [15:0] instr_operand = 16'h0000;
  reg nmi_pin_n = 1'b1, irq_pin_n = 1'b1, wake_pin_n = 1'b1;
  wire instr_ready, instr_done, mem_wr_en, stack_req, clocks_stop, wake_vf, q_adj;
  wire [15:0] mem_wr_addr, index_x, index_y, stack_ptr, tmp;
  wire [7:0] mem_wr_data, accum_a, accum_b, cc_reg;
  integer err_count = 0;
  integer comparisons = 0;
  integer cycles = 0;
  integer cyc;
  reg side_seen;
  reg [7:0] ea = 8'h00, eb = 8'h00, ecc = 8'hd0;
  reg [15:0] ex = 16'h0000, ey = 16'h0000, esp = 16'h0000, et = 16'h0000;
  sshe_exec sshe_exec_i (.ref_clk(ref_clk), .reset_n(reset_n), .instr_valid(instr_valid),
    .instr_opcode(instr_opcode), .instr_page2(instr_page2), .instr_postbyte(instr_postbyte),
    .instr_addr(instr_addr), .instr_operand(instr_operand), .instr_ready(instr_ready),
    .instr_done(instr_done), .mem_wr_en(mem_wr_en), .mem_wr_addr(mem_wr_addr),
    .mem_wr_data(mem_wr_data), .stack_req(stack_req), .clocks_stop(clocks_stop),
    .wake_vector_fetch(wake_vf), .queue_adjust(q_adj), .nonmaskable_request_line_n(nmi_pin_n),
    .irq_n(irq_pin_n), .wake_reset_n(wake_pin_n), .accum_a(accum_a), .accum_b(accum_b),
    .index_x(index_x), .index_y(index_y), .stack_ptr(stack_ptr), .hidden_temp_register(tmp),
    .condition_flags_register(cc_reg));
  sshe_mem_model sshe_mem_model_i (.ref_clk(ref_clk), .mem_wr_en(mem_wr_en),
    .mem_wr_addr(mem_wr_addr), .mem_wr_data(mem_wr_data));
  always #50 ref_clk = ~ref_clk;
  // hang guard, far above the few hundred cycles the run needs
  always @(posedge ref_clk)
  begin
    cycles = cycles + 1;
    if (cycles == 5000)
    begin
      err_count = err_count + 1;
      close_out;
    end
  end
  task close_out;
    begin
      if (err_count == 0 && comparisons > 0)
        $display("RESULT: PASS");
      else
        $display("RESULT: FAIL");
      $finish;
    end
  endtask
  task check(input [15:0] seen, input [15:0] expd);
    begin
      comparisons = comparisons + 1;
      if (seen !== expd)
      begin
        err_count = err_count + 1;
        $display("BAD %0t seen %h expected %h", $time, seen, expd);
      end
    end
  endtask
  // borrow and overflow worked out from the sign bits
  function [7:0] sub_flags(input [7:0] c, input [15:0] m, input [15:0] s, input w);
    reg [15:0] r;
    reg mh, sh, rh, z;
    begin
      r = m - s;
      mh = w ? m[15] : m[7];
      sh = w ? s[15] : s[7];
      rh = w ? r[15] : r[7];
      z = w ? (r == 16'h0000) : (r[7:0] == 8'h00);
      sub_flags = {c[7:4], rh, z, (mh & ~sh & ~rh) | (~mh & sh & rh),
        (~mh & sh) | (sh & rh) | (rh & ~mh)};
    end
  endfunction
  // offered after an edge, taken at the next while idle, held until then
  task issue(input pg, input [7:0] op, input [7:0] pb, input [15:0] ad, input [15:0] od);
    integer n;
    begin
      @(posedge ref_clk);
      instr_valid <= 1'b1;
      instr_page2 <= pg;
      instr_opcode <= op;
      instr_postbyte <= pb;
      instr_addr <= ad;
      instr_operand <= od;
      @(posedge ref_clk);
      instr_valid <= 1'b0;
      cyc = 0;
      side_seen = 1'b0;
      // the retire pulse of a one-cycle instruction follows the taking edge
      for (n = 0; n < 8 && cyc == 0; n = n + 1)
      begin
        #1;
        if (stack_req !== 1'b0 || clocks_stop !== 1'b0)
          side_seen = 1'b1;
        if (instr_done === 1'b1)
          cyc = n + 1;
        else
          @(posedge ref_clk);
      end
    end
  endtask
  task check_regs;
    begin
      check(accum_a, ea);
      check(accum_b, eb);
      check(index_x, ex);
      check(index_y, ey);
      check(stack_ptr, esp);
      check(tmp, et);
      check(cc_reg, ecc);
    end
  endtask
  task t_standby;
    begin
      issue(1'b1, 8'h3e, 8'h00, 16'h0000, 16'h0000);
      check(cyc, 2);
      check(side_seen, 1'b0);
      check_regs;
    end
  endtask
  // every form of both 8-bit subtracts, with borrow and overflow cases
  task t_sub8;
    integer k;
    reg [63:0] ops, ods;
    reg [7:0] od;
    begin
      ops = 64'h8090b0a0c0d0f0e0;
      ods = 64'h017f010002007fff;
      for (k = 0; k < 8; k = k + 1)
      begin
        od = ods[63 - 8 * k -: 8];
        issue(1'b0, ops[63 - 8 * k -: 8], 8'h00, 16'h0010, {8'ha5, od});
        if (k < 4)
        begin
          ecc = sub_flags(ecc, {8'h00, ea}, {8'h00, od}, 1'b0);
          ea = ea - od;
        end
        else
        begin
          ecc = sub_flags(ecc, {8'h00, eb}, {8'h00, od}, 1'b0);
          eb = eb - od;
        end
        check(cyc, 1);
        check_regs;
      end
    end
  endtask
  // every destination, all three sources, top postbyte bit set once
  task t_sext;
    integer k;
    reg [39:0] pbs;
    reg [7:0] pb, s;
    reg [15:0] v;
    begin
      pbs = 40'h0596270304;
      for (k = 0; k < 5; k = k + 1)
      begin
        pb = pbs[39 - 8 * k -: 8];
        s = (pb[6:4] == 3'h0) ? ea : (pb[6:4] == 3'h1) ? eb : ecc;
        v = {{8{s[7]}}, s};
        issue(1'b0, 8'hb7, pb, 16'h0000, 16'h0000);
        case (pb[3:0])
          4'h3: et = v;
          4'h4: {ea, eb} = v;
          4'h5: ex = v;
          4'h6: ey = v;
          default: esp = v;
        endcase
        check(cyc, 1);
        check_regs;
      end
    end
  endtask
  // all six stores in direct, indexed and extended forms
  task t_store;
    integer k;
    reg [3:0] lo;
    reg [7:0] a0;
    reg [15:0] v;
    reg w;
    reg [3:0] hi;
    begin
      for (k = 0; k < 18; k = k + 1)
      begin
        lo = 4'ha + k % 6;
        a0 = 8'h40 + k * 4;
        w = lo >= 4'hc;
        v = (lo == 4'ha) ? {8'h00, ea} : (lo == 4'hb) ? {8'h00, eb} : (lo == 4'hc) ? {ea, eb}
          : (lo == 4'hd) ? ey : (lo == 4'he) ? ex : esp;
        hi = (k < 6) ? 4'h5 : (k < 12) ? 4'h6 : 4'h7;
        issue(1'b0, {hi, lo}, 8'h00, {8'h00, a0}, 16'h0000);
        // the last byte lands in memory at the edge after the retire pulse
        @(posedge ref_clk);
        #1;
        if (w)
        begin
          check(cyc, 2);
          check({sshe_mem_model_i.mem[a0], sshe_mem_model_i.mem[a0 + 8'h01]}, v);
          ecc = {ecc[7:4], v[15], v == 16'h0000, 1'b0, ecc[0]};
        end
        else
        begin
          check(cyc, 1);
          check(sshe_mem_model_i.mem[a0], v);
          ecc = {ecc[7:4], v[7], v[7:0] == 8'h00, 1'b0, ecc[0]};
        end
        check(cc_reg, ecc);
        check_regs;
      end
    end
  endtask
  task t_sub_double;
    integer k;
    reg [31:0] ops;
    reg [63:0] ods;
    reg [15:0] od;
    begin
      ops = 32'h8393b3a3;
      ods = 64'h0080ffff80000001;
      for (k = 0; k < 4; k = k + 1)
      begin
        od = ods[63 - 16 * k -: 16];
        issue(1'b0, ops[31 - 8 * k -: 8], 8'h00, 16'h0020, od);
        ecc = sub_flags(ecc, {ea, eb}, od, 1'b1);
        {ea, eb} = {ea, eb} - od;
        check(cyc, 1);
        check(instr_ready, 1'b1);
        check_regs;
      end
    end
  endtask
  // standby with stop-disable cleared in place, then woken by one pin
  task t_wake(input xm, input [2:0] pins, input vf);
    integer n;
    reg vf_seen, qa_seen;
    begin
      @(posedge ref_clk);
      #1;
      ecc = {1'b0, xm, ecc[5:0]};
      sshe_exec_i.cc_ff = ecc;
      issue(1'b1, 8'h3e, 8'h00, 16'h0000, 16'h0000);
      #1;
      check(cyc, 0);
      check({side_seen, clocks_stop}, 2'h3);
      check_regs;
      @(posedge ref_clk);
      {wake_pin_n, nmi_pin_n, irq_pin_n} <= ~pins;
      cyc = 0;
      vf_seen = 1'b0;
      qa_seen = 1'b0;
      // three-stage pin filter, then one edge to retire or to realign
      for (n = 0; n < 12 && cyc == 0; n = n + 1)
      begin
        @(posedge ref_clk);
        #1;
        vf_seen = vf_seen | wake_vf;
        qa_seen = qa_seen | q_adj;
        if (instr_done === 1'b1)
          cyc = n + 1;
      end
      check(cyc, vf ? 16'h0005 : 16'h0006);
      check({vf_seen, qa_seen}, {vf, !vf});
      check(clocks_stop, 1'b0);
      check_regs;
      @(posedge ref_clk);
      {wake_pin_n, nmi_pin_n, irq_pin_n} <= 3'h7;
      // let the filtered level fall before the next standby
      repeat (4) @(posedge ref_clk);
    end
  endtask
  // reset held four edges, released by the bench at a rising edge
  initial
  begin
    repeat (3) @(posedge ref_clk);
    #1;
    check_regs;
    @(posedge ref_clk);
    reset_n <= 1'b1;
    t_standby;
    t_sub8;
    t_sext;
    t_store;
    t_sub_double;
    t_store;
    t_wake(1'b1, 3'h2, 1'b0);
    t_wake(1'b0, 3'h2, 1'b1);
    t_wake(1'b0, 3'h4, 1'b1);
    t_wake(1'b1, 3'h1, 1'b0);
    close_out;
  end
endmodule

// file: verilog/sshe_exec.v
// Purpose: execution unit for sign-extend transfer, stores, subtracts
//   and the standby instruction of a 16-bit core
// Assumes: the fetch stage hands over a decoded instruction with its
//   postbyte, effective address and memory operand already resolved
// Notes: memory writes are byte wide, high byte first for 16-bit stores
// Contract
// - sign-extend postbyte picks source and destination
// - store A writes byte, A unchanged
// - store B writes byte, B unchanged
// - store D writes A then B
// - store SP high byte then low
// - store X high byte then low
// - store Y high byte then low
// - stores set N Z, clear V, keep C
// - standby disabled acts as two-cycle nop
// - standby enabled stacks context, stops clocks
// - unmasked wake resumes with vector fetch
// - masked wake does two-cycle recovery, continues
// - subtract into A writes A
// - subtract into B writes B
// - subtract into D is sixteen bits
// - overflow from two's complement sign rule
// - carry is the borrow
// - carry follows the bit-seven expression, bit fifteen for subtract into D
//
// Added by the designer: the address-and-strobe port.
`timescale 1ns/100ps
`include "sshe_defines.vh"
module sshe_exec
(
  ref_clk,
  reset_n,
  instr_valid,
  instr_opcode,
  instr_page2,
  instr_postbyte,
  instr_addr,
  instr_operand,
  instr_ready,
  instr_done,
  mem_wr_en,
  mem_wr_addr,
  mem_wr_data,
  stack_req,
  clocks_stop,
  wake_vector_fetch,
  queue_adjust,
  nonmaskable_request_line_n,
  irq_n,
  wake_reset_n,
  accum_a,
  accum_b,
  index_x,
  index_y,
  stack_ptr,
  hidden_temp_register,
  condition_flags_register
);
  input wire ref_clk;
  input wire reset_n;
  input wire instr_valid;
  input wire [7:0] instr_opcode;
  input wire instr_page2;
  input wire [7:0] instr_postbyte;
  input wire [15:0] instr_addr;
  input wire [15:0] instr_operand;
  output wire instr_ready;
  output reg instr_done;
  output reg mem_wr_en;
  output reg [15:0] mem_wr_addr;
  output reg [7:0] mem_wr_data;
  output reg stack_req;
  output reg clocks_stop;
  output reg wake_vector_fetch;
  output reg queue_adjust;
  input wire nonmaskable_request_line_n;
  input wire irq_n;
  input wire wake_reset_n;
  output wire [7:0] accum_a;
  output wire [7:0] accum_b;
  output wire [15:0] index_x;
  output wire [15:0] index_y;
  output wire [15:0] stack_ptr;
  output wire [15:0] hidden_temp_register;
  output wire [7:0] condition_flags_register;

  localparam ST_IDLE = 3'h0;
  localparam ST_WR_LO = 3'h1;
  localparam ST_NOP = 3'h2;
  localparam ST_STACK = 3'h3;
  localparam ST_STANDBY = 3'h4;
  localparam ST_RECOVER = 3'h5;

  reg [2:0] state_ff;
  reg [7:0] a_ff;
  reg [7:0] b_ff;
  reg [15:0] x_ff;
  reg [15:0] y_ff;
  reg [15:0] sp_ff;
  reg [15:0] tmp_ff;
  reg [7:0] cc_ff;
  reg [7:0] lo_byte_ff;
  reg [15:0] lo_addr_ff;
  reg [1:0] cnt_ff;
  // three-stage pin synchronisers for the asynchronous wake lines
  reg [2:0] nmi_sync_ff;
  reg [2:0] irq_sync_ff;
  reg [2:0] rst_sync_ff;
  reg nmi_lvl_ff;
  reg irq_lvl_ff;
  reg rst_lvl_ff;

  // which store, if any; 0 none, 1 A, 2 B, 3 D, 4 Y, 5 X, 6 SP
  function [2:0] store_sel;
    input [7:0] op;
    reg [3:0] idx;
    begin
      idx = op[3:0] - 4'h9;
      if ((op[7:4] == 4'h5 || op[7:4] == 4'h6 || op[7:4] == 4'h7) && op[3:0] >= 4'ha)
        store_sel = idx[2:0];
      else
        store_sel = 3'h0;
    end
  endfunction

  // subtract kind; 0 none, 1 into A, 2 into B, 3 into D
  function [1:0] sub_sel;
    input [7:0] op;
    begin
      case (op)
        `SSHE_OP_SUB_A_IMM, `SSHE_OP_SUB_A_DIR, `SSHE_OP_SUB_A_EXT, `SSHE_OP_SUB_A_IDX:
          sub_sel = 2'h1;
        `SSHE_OP_SUB_B_IMM, `SSHE_OP_SUB_B_DIR, `SSHE_OP_SUB_B_EXT, `SSHE_OP_SUB_B_IDX:
          sub_sel = 2'h2;
        `SSHE_OP_SUB_D_IMM, `SSHE_OP_SUB_D_DIR, `SSHE_OP_SUB_D_EXT, `SSHE_OP_SUB_D_IDX:
          sub_sel = 2'h3;
        default:
          sub_sel = 2'h0;
      endcase
    end
  endfunction

  assign accum_a = a_ff;
  assign accum_b = b_ff;
  assign index_x = x_ff;
  assign index_y = y_ff;
  assign stack_ptr = sp_ff;
  assign hidden_temp_register = tmp_ff;
  assign condition_flags_register = cc_ff;
  assign instr_ready = (state_ff == ST_IDLE);

  wire [2:0] st_kind = store_sel(instr_opcode);
  wire [1:0] sb_kind = instr_page2 ? 2'h0 : sub_sel(instr_opcode);
  wire is_store = !instr_page2 && (st_kind != 3'h0);
  wire is_sext = !instr_page2 && (instr_opcode == `SSHE_OP_SEXT);
  wire is_standby = instr_page2 && (instr_opcode == `SSHE_OP_STANDBY);
  wire take = instr_valid && instr_ready;

  // value being stored, sixteen bits for the wide forms
  reg [15:0] st_val;
  reg st_wide;
  always @*
  begin
    st_val = 16'h0000;
    st_wide = 1'b1;
    case (st_kind)
      3'h1:
      begin
        st_val = {8'h00, a_ff};
        st_wide = 1'b0;
      end
      3'h2:
      begin
        st_val = {8'h00, b_ff};
        st_wide = 1'b0;
      end
      3'h3: st_val = {a_ff, b_ff};
      3'h4: st_val = y_ff;
      3'h5: st_val = x_ff;
      3'h6: st_val = sp_ff;
      default: st_val = 16'h0000;
    endcase
  end

  // subtract datapath; results keep their width, the borrow comes from the top bits
  wire [7:0] sub_m8 = (sb_kind == 2'h1) ? a_ff : b_ff;
  wire [7:0] sub_s8 = instr_operand[7:0];
  wire [7:0] sub_r8 = sub_m8 - sub_s8;
  wire [15:0] sub_m16 = {a_ff, b_ff};
  wire [15:0] sub_r16 = sub_m16 - instr_operand;
  // bit-seven borrow equation, equal to unsigned compare
  wire sub_c8 = (~sub_m8[7] & sub_s8[7]) | (sub_s8[7] & sub_r8[7]) | (sub_r8[7] & ~sub_m8[7]);
  wire sub_v8 = (sub_m8[7] & ~sub_s8[7] & ~sub_r8[7]) | (~sub_m8[7] & sub_s8[7] & sub_r8[7]);
  wire sub_c16 = (~sub_m16[15] & instr_operand[15]) | (instr_operand[15] & sub_r16[15])
    | (sub_r16[15] & ~sub_m16[15]);
  wire sub_v16 = (sub_m16[15] & ~instr_operand[15] & ~sub_r16[15])
    | (~sub_m16[15] & instr_operand[15] & sub_r16[15]);

  // sign-extend source byte and its 16-bit image
  reg [7:0] sx_src;
  always @*
  begin
    case (instr_postbyte[6:4]) // top bit of postbyte ignored
      `SSHE_SRC_A: sx_src = a_ff;
      `SSHE_SRC_B: sx_src = b_ff;
      `SSHE_SRC_CC: sx_src = cc_ff;
      default: sx_src = a_ff;
    endcase
  end
  wire [15:0] sx_val = {{8{sx_src[7]}}, sx_src};

  // wake lines: a change counts once stages two and three agree
  always @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      nmi_sync_ff <= 3'h7;
      irq_sync_ff <= 3'h7;
      rst_sync_ff <= 3'h7;
      nmi_lvl_ff <= 1'b0;
      irq_lvl_ff <= 1'b0;
      rst_lvl_ff <= 1'b0;
    end
    else
    begin
      nmi_sync_ff <= {nmi_sync_ff[1:0], nonmaskable_request_line_n};
      irq_sync_ff <= {irq_sync_ff[1:0], irq_n};
      rst_sync_ff <= {rst_sync_ff[1:0], wake_reset_n};
      if (nmi_sync_ff[1] == nmi_sync_ff[2])
        nmi_lvl_ff <= ~nmi_sync_ff[2];
      if (irq_sync_ff[1] == irq_sync_ff[2])
        irq_lvl_ff <= ~irq_sync_ff[2];
      if (rst_sync_ff[1] == rst_sync_ff[2])
        rst_lvl_ff <= ~rst_sync_ff[2];
    end
  end

  // main sequencer and register file
  always @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      state_ff <= ST_IDLE;
      a_ff <= 8'h00;
      b_ff <= 8'h00;
      x_ff <= 16'h0000;
      y_ff <= 16'h0000;
      sp_ff <= 16'h0000;
      tmp_ff <= 16'h0000;
      cc_ff <= `SSHE_CC_RESET;
      lo_byte_ff <= 8'h00;
      lo_addr_ff <= 16'h0000;
      cnt_ff <= 2'h0;
      instr_done <= 1'b0;
      mem_wr_en <= 1'b0;
      mem_wr_addr <= 16'h0000;
      mem_wr_data <= 8'h00;
      stack_req <= 1'b0;
      clocks_stop <= 1'b0;
      wake_vector_fetch <= 1'b0;
      queue_adjust <= 1'b0;
    end
    else
    begin
      instr_done <= 1'b0;
      mem_wr_en <= 1'b0;
      stack_req <= 1'b0;
      wake_vector_fetch <= 1'b0;
      queue_adjust <= 1'b0;
      case (state_ff)
        ST_IDLE:
        begin
          if (take && is_store)
          begin
            mem_wr_en <= 1'b1;
            mem_wr_addr <= instr_addr;
            // high byte first at M, low byte at M+1
            mem_wr_data <= st_wide ? st_val[15:8] : st_val[7:0];
            lo_byte_ff <= st_val[7:0];
            lo_addr_ff <= instr_addr + 16'h0001;
            cc_ff[`SSHE_CC_NEG] <= st_wide ? st_val[15] : st_val[7];
            cc_ff[`SSHE_CC_ZERO] <= st_wide ? (st_val == 16'h0000)
              : (st_val[7:0] == 8'h00);
            cc_ff[`SSHE_CC_OVF] <= 1'b0; // carry left alone
            if (st_wide)
              state_ff <= ST_WR_LO;
            else
              instr_done <= 1'b1;
          end
          else if (take && sb_kind == 2'h3)
          begin
            {a_ff, b_ff} <= sub_r16;
            cc_ff[`SSHE_CC_NEG] <= sub_r16[15];
            cc_ff[`SSHE_CC_ZERO] <= (sub_r16 == 16'h0000);
            cc_ff[`SSHE_CC_OVF] <= sub_v16;
            cc_ff[`SSHE_CC_CARRY] <= sub_c16;
            instr_done <= 1'b1;
          end
          else if (take && sb_kind != 2'h0)
          begin
            if (sb_kind == 2'h1)
              a_ff <= sub_r8;
            else
              b_ff <= sub_r8;
            cc_ff[`SSHE_CC_NEG] <= sub_r8[7];
            cc_ff[`SSHE_CC_ZERO] <= (sub_r8 == 8'h00);
            cc_ff[`SSHE_CC_OVF] <= sub_v8;
            cc_ff[`SSHE_CC_CARRY] <= sub_c8;
            instr_done <= 1'b1;
          end
          else if (take && is_sext)
          begin
            // flags untouched by the transfer
            case (instr_postbyte[3:0])
              `SSHE_DST_TMP: tmp_ff <= sx_val;
              `SSHE_DST_D: {a_ff, b_ff} <= sx_val;
              `SSHE_DST_X: x_ff <= sx_val;
              `SSHE_DST_Y: y_ff <= sx_val;
              `SSHE_DST_SP: sp_ff <= sx_val;
              default: tmp_ff <= tmp_ff;
            endcase
            instr_done <= 1'b1;
          end
          else if (take && is_standby)
          begin
            // sample the disable bit at execution time
            if (cc_ff[`SSHE_CC_STOPDIS])
            begin
              cnt_ff <= `SSHE_NOP_CYCLES - 2'h1;
              state_ff <= ST_NOP;
            end
            else
            begin
              stack_req <= 1'b1;
              state_ff <= ST_STACK;
            end
          end
          else if (take)
            instr_done <= 1'b1; // unknown opcodes retire untouched
        end
        ST_WR_LO:
        begin
          mem_wr_en <= 1'b1;
          mem_wr_addr <= lo_addr_ff;
          mem_wr_data <= lo_byte_ff;
          instr_done <= 1'b1;
          state_ff <= ST_IDLE;
        end
        ST_NOP:
        begin
          // second cycle of the disabled standby
          if (cnt_ff == 2'h1)
          begin
            instr_done <= 1'b1;
            state_ff <= ST_IDLE;
          end
          cnt_ff <= cnt_ff - 2'h1;
        end
        ST_STACK:
        begin
          // context is stacked by the fetch stage; stop clocks next
          clocks_stop <= 1'b1;
          state_ff <= ST_STANDBY;
        end
        ST_STANDBY:
        begin
          // registers hold: nothing here writes them
          if (rst_lvl_ff)
          begin
            clocks_stop <= 1'b0;
            wake_vector_fetch <= 1'b1;
            instr_done <= 1'b1;
            state_ff <= ST_IDLE;
          end
          else if (nmi_lvl_ff && !cc_ff[`SSHE_CC_XMASK])
          begin
            clocks_stop <= 1'b0;
            wake_vector_fetch <= 1'b1;
            instr_done <= 1'b1;
            state_ff <= ST_IDLE;
          end
          else if (nmi_lvl_ff || irq_lvl_ff)
          begin
            // masked wake: realign the queue before going on
            clocks_stop <= 1'b0;
            queue_adjust <= 1'b1;
            cnt_ff <= `SSHE_RECOVER_CYCLES - 2'h1;
            state_ff <= ST_RECOVER;
          end
        end
        ST_RECOVER:
        begin
          if (cnt_ff == 2'h1)
          begin
            instr_done <= 1'b1;
            state_ff <= ST_IDLE;
          end
          cnt_ff <= cnt_ff - 2'h1;
        end
        default:
          state_ff <= ST_IDLE;
      endcase
    end
  end
endmodule
